// ===== hw/csr_fast_decode.sv
// Decoder of the fast interrupt level field into a one-hot level select.
`timescale 1ns/1ns
module csr_fast_decode #(
    parameter int LEVELS = 8
) (
    // Field inputs.
    input wire logic i_enable,
    input wire logic [2:0] i_level,
    // Decoded select.
    output logic [LEVELS-1:0] o_sel
);
    // ****************************************
    // One-hot decode, one bit per level
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < LEVELS; g++) begin : g_lvl
            // Only one level can be selected at a time.
            assign o_sel[g] = i_enable && (i_level == 3'(g));
        end
    endgenerate
endmodule : csr_fast_decode

// ===== hw/csr_pkg.sv
// Package with register offsets, field positions and reset values of the system control bank.
package csr_pkg;
    // ****************************************
    // Register offsets on the internal register bus
    // ****************************************
    localparam logic [7:0] OFF_SP_HIGH = 8'hd8;
    localparam logic [7:0] OFF_SP_LOW = 8'hd9;
    localparam logic [7:0] OFF_SYS_MODE = 8'hde;
    localparam logic [7:0] OFF_HALT_GUARD = 8'hfb;
    // ****************************************
    // Field layouts and reset values
    // ****************************************
    localparam logic [7:0] HALT_KEY = 8'ha5;
    localparam logic [7:0] HALT_GUARD_RST = 8'h00;
    localparam int SYM_GIE_BIT = 0;
    localparam int SYM_FIE_BIT = 1;
    localparam int SYM_LVL_LSB = 2;
    localparam int SYM_LVL_MSB = 4;
    localparam int SYM_ZERO_BIT = 7;
    localparam logic [7:0] SYM_WR_MASK = 8'h1f;
    localparam logic [1:0] SYM_EN_RST = 2'h0;
    localparam logic [2:0] SYM_LVL_RST = 3'h0;
    localparam logic [7:0] SP_RST = 8'h00;

    // Register bus request from the CPU core.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csr_req_t;
endpackage : csr_pkg

// ===== hw/csr_sysctl_regs.sv
// System control register bank: stack pointer, halt guard and system mode.
//
// Summary of operation
// - High stack pointer byte, fully read/write.
// - Low stack pointer byte, fully read/write.
// - Stack pointer bytes are not reset.
// - Key pattern in guard register permits halt.
// - Halt without key causes reset, not halt.
// - Fast interrupt enable applies selected level.
// - Only one fast interrupt level at once.
`timescale 1ns/1ns
module csr_sysctl_regs (
    // Clock and reset.
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    // Register bus from the CPU core.
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    output logic [7:0] O_RDATA,
    output logic O_HIT,
    // Core controls.
    input wire logic I_HALT_EXEC,
    input wire logic I_EI_EXEC,
    input wire logic I_DI_EXEC,
    // Outputs to the core.
    output logic [15:0] O_SP,
    output logic O_HALT,
    output logic O_HALT_RESET,
    output logic O_GIE,
    output logic [7:0] O_FAST_SEL
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rst_s1_r;
    logic rst_n_r;

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    csr_pkg::csr_req_t req;
    wire sel_sph = (req.addr == csr_pkg::OFF_SP_HIGH);
    wire sel_spl = (req.addr == csr_pkg::OFF_SP_LOW);
    wire sel_sym = (req.addr == csr_pkg::OFF_SYS_MODE);
    wire sel_grd = (req.addr == csr_pkg::OFF_HALT_GUARD);
    wire wr_sph = req.wr && sel_sph;
    wire wr_spl = req.wr && sel_spl;
    wire wr_sym = req.wr && sel_sym;
    wire wr_grd = req.wr && sel_grd;

    // Bus fields are gathered into one request.
    assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] sph_r;
    logic [7:0] spl_r;
    logic [7:0] guard_r;
    logic [2:0] lvl_r;
    logic fie_r;
    logic gie_r;
    logic halt_r;
    logic halt_rst_r;
    logic [7:0] rdata_r;
    logic gie_nxt;
    wire key_ok = (guard_r == csr_pkg::HALT_KEY);

    // Stack pointer bytes have no reset; they hold whatever was last written.
    always_ff @(posedge I_MCLK) begin
        if (wr_sph) begin
            sph_r <= req.wdata;
        end
        if (wr_spl) begin
            spl_r <= req.wdata;
        end
    end

    // Global enable follows the enable and disable instructions; a write also loads it.
    always_comb begin
        gie_nxt = gie_r;
        if (wr_sym) begin
            gie_nxt = req.wdata[csr_pkg::SYM_GIE_BIT];
        end
        if (I_DI_EXEC) begin
            gie_nxt = 1'b0;
        end
        if (I_EI_EXEC) begin
            gie_nxt = 1'b1;
        end
    end

    // Guard and mode registers, reset to their documented values.
    always_ff @(posedge I_MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            guard_r <= csr_pkg::HALT_GUARD_RST;
            lvl_r <= csr_pkg::SYM_LVL_RST;
            fie_r <= 1'b0;
            gie_r <= 1'b0;
        end else begin
            if (wr_grd) begin
                guard_r <= req.wdata;
            end
            if (wr_sym) begin
                lvl_r <= req.wdata[csr_pkg::SYM_LVL_MSB:csr_pkg::SYM_LVL_LSB];
                fie_r <= req.wdata[csr_pkg::SYM_FIE_BIT];
            end
            gie_r <= gie_nxt;
        end
    end

    // A halt instruction halts with the key loaded, otherwise asks for reset.
    always_ff @(posedge I_MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            halt_r <= 1'b0;
            halt_rst_r <= 1'b0;
        end else begin
            halt_r <= I_HALT_EXEC && key_ok;
            halt_rst_r <= I_HALT_EXEC && !key_ok;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire [7:0] sym_rd = {1'b0, 2'b00, lvl_r, fie_r, gie_r};
    wire [7:0] rd_mux = sel_sph ? sph_r :
                        sel_spl ? spl_r :
                        sel_sym ? sym_rd :
                        sel_grd ? guard_r : 8'h00;

    // Read data is registered; unmapped addresses read zero.
    always_ff @(posedge I_MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            rdata_r <= rd_mux;
        end
    end

    assign O_RDATA = rdata_r;
    assign O_HIT = sel_sph | sel_spl | sel_sym | sel_grd;
    assign O_SP = {sph_r, spl_r};
    assign O_HALT = halt_r;
    assign O_HALT_RESET = halt_rst_r;
    assign O_GIE = gie_r;

    // ****************************************
    // Fast interrupt level select
    // ****************************************
    csr_fast_decode #(
        .LEVELS(8)
    ) u_fast (
        .i_enable(fie_r),
        .i_level(lvl_r),
        .o_sel(O_FAST_SEL)
    );

    // ****************************************
    // Check helpers
    // ****************************************
    logic sph_seen_r;
    logic spl_seen_r;

    // Marks each stack byte once written, so hold checks never compare unknown contents.
    always_ff @(posedge I_MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sph_seen_r <= 1'b0;
            spl_seen_r <= 1'b0;
        end else begin
            if (wr_sph) begin
                sph_seen_r <= 1'b1;
            end
            if (wr_spl) begin
                spl_seen_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    halt_key_ok_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_HALT_EXEC && guard_r == 8'ha5) |=> (O_HALT && !O_HALT_RESET))
        else $error("Halt with key did not halt.");
    halt_bad_rst_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_HALT_EXEC && guard_r != 8'ha5) |=> (O_HALT_RESET && !O_HALT))
        else $error("Halt without key did not reset.");
    sph_write_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_WR && I_ADDR == 8'hd8) |=> (O_SP[15:8] == $past(I_WDATA)))
        else $error("High stack byte not written.");
    spl_write_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_WR && I_ADDR == 8'hd9) |=> (O_SP[7:0] == $past(I_WDATA)))
        else $error("Low stack byte not written.");
    sp_hold_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (sph_seen_r && !wr_sph) |=> $stable(O_SP[15:8]))
        else $error("High stack byte changed without a write.");
    spl_hold_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (spl_seen_r && !wr_spl) |=> $stable(O_SP[7:0]))
        else $error("Low stack byte changed without a write.");
    fast_sel_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_WR && I_ADDR == 8'hde && I_WDATA[1]) |=> O_FAST_SEL[$past(I_WDATA[4:2])])
        else $error("Fast level not applied.");
    fast_onehot_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        $onehot0(O_FAST_SEL))
        else $error("More than one fast level selected.");
    fast_off_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_WR && I_ADDR == 8'hde && !I_WDATA[1]) |=> (O_FAST_SEL == 8'h00))
        else $error("Fast level selected while disabled.");
    sym_rsvd_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_RD && I_ADDR == csr_pkg::OFF_SYS_MODE) |=> (O_RDATA[7:5] == 3'h0))
        else $error("Unused mode bits read nonzero.");
    grd_write_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_WR && I_ADDR == csr_pkg::OFF_HALT_GUARD) |=> (guard_r == $past(I_WDATA)))
        else $error("Guard register not written.");
    di_clears_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        (I_DI_EXEC && !I_EI_EXEC) |=> !O_GIE)
        else $error("Disable instruction did not clear global enable.");
    ei_sets_a: assert property (@(posedge I_MCLK) disable iff (!rst_n_r)
        I_EI_EXEC |=> O_GIE)
        else $error("Enable instruction did not set global enable.");
endmodule : csr_sysctl_regs

// ===== testbench/csr_sysctl_regs_bench.sv
// Self-checking bench for the system control register bank.
`timescale 1ns/1ns
module csr_sysctl_regs_bench;
    // ****************************************
    // Stimulus signals and counters
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic halt = 1'b0;
    logic ei = 1'b0;
    logic di = 1'b0;
    logic [7:0] rdata;
    logic hit;
    logic [15:0] sp;
    logic halt_ok;
    logic halt_rst;
    logic gie;
    logic [7:0] fast_sel;
    int failures = 0;
    int samples_checked = 0;

    // The clock toggles every half period of 50 ns.
    always #50 clk = ~clk;

    csr_sysctl_regs DUT (.I_MCLK(clk), .I_RESETN(rst_n), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
        .I_WDATA(wdata), .O_RDATA(rdata), .O_HIT(hit), .I_HALT_EXEC(halt), .I_EI_EXEC(ei),
        .I_DI_EXEC(di), .O_SP(sp), .O_HALT(halt_ok), .O_HALT_RESET(halt_rst), .O_GIE(gie),
        .O_FAST_SEL(fast_sel));

    // ****************************************
    // Bus cycles and comparison
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : write_reg

    task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        check("read data", {8'h00, rdata}, {8'h00, exp});
    endtask : read_chk

    // Pulses one core control for a single cycle; outputs are settled afterwards.
    task automatic strobe(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : strobe

    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_stack;
        logic [7:0] pat [2] = '{8'h5a, 8'hc3};
        foreach (pat[i]) begin
            write_reg(csr_pkg::OFF_SP_HIGH, pat[i]);
            write_reg(csr_pkg::OFF_SP_LOW, ~pat[i]);
            check("stack pointer", sp, {pat[i], ~pat[i]});
            read_chk(csr_pkg::OFF_SP_HIGH, pat[i]);
            read_chk(csr_pkg::OFF_SP_LOW, ~pat[i]);
        end
    endtask : test_stack

    task automatic test_halt;
        logic [7:0] key [4] = '{8'h00, csr_pkg::HALT_KEY, 8'ha4, 8'h5a};
        read_chk(csr_pkg::OFF_HALT_GUARD, csr_pkg::HALT_GUARD_RST);
        foreach (key[i]) begin
            write_reg(csr_pkg::OFF_HALT_GUARD, key[i]);
            read_chk(csr_pkg::OFF_HALT_GUARD, key[i]);
            strobe(halt);
            check("halt", {15'h0, halt_ok}, {15'h0, key[i] == csr_pkg::HALT_KEY});
            check("halt reset", {15'h0, halt_rst}, {15'h0, key[i] != csr_pkg::HALT_KEY});
        end
    endtask : test_halt

    task automatic test_mode;
        logic [7:0] v;
        read_chk(csr_pkg::OFF_SYS_MODE, 8'h00);
        for (int l = 0; l < 8; l++) begin
            v = 8'he2 | 8'(l << 2);
            write_reg(csr_pkg::OFF_SYS_MODE, v);
            check("fast select", {8'h00, fast_sel}, 16'(1 << l));
            read_chk(csr_pkg::OFF_SYS_MODE, v & csr_pkg::SYM_WR_MASK);
        end
        write_reg(csr_pkg::OFF_SYS_MODE, 8'h1c);
        check("fast select off", {8'h00, fast_sel}, 16'h0000);
        strobe(ei);
        check("global enable", {15'h0, gie}, 16'h0001);
        strobe(di);
        check("global disable", {15'h0, gie}, 16'h0000);
        write_reg(csr_pkg::OFF_SYS_MODE, 8'h1f);
        check("global enable by write", {15'h0, gie}, 16'h0001);
        check("fast select top", {8'h00, fast_sel}, 16'h0080);
    endtask : test_mode

    task automatic test_unmapped;
        write_reg(8'hd7, 8'hff);
        read_chk(8'h10, 8'h00);
        check("unmapped hit", {15'h0, hit}, 16'h0000);
        read_chk(csr_pkg::OFF_HALT_GUARD, 8'h5a);
        check("mapped hit", {15'h0, hit}, 16'h0001);
    endtask : test_unmapped

    // A mid-run reset restores guard and mode but leaves the stack pointer alone.
    task automatic test_reset;
        write_reg(csr_pkg::OFF_SP_HIGH, 8'h3c);
        write_reg(csr_pkg::OFF_SP_LOW, 8'h96);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check("stack pointer kept", sp, 16'h3c96);
        check("global enable after reset", {15'h0, gie}, 16'h0000);
        check("fast select after reset", {8'h00, fast_sel}, 16'h0000);
        check("halt after reset", {14'h0, halt_ok, halt_rst}, 16'h0000);
        read_chk(csr_pkg::OFF_HALT_GUARD, csr_pkg::HALT_GUARD_RST);
        read_chk(csr_pkg::OFF_SYS_MODE, 8'h00);
    endtask : test_reset

    // Main sequence: reset for 8 cycles, then every scenario in turn.
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        test_stack();
        test_halt();
        test_mode();
        test_unmapped();
        test_reset();
        give_verdict();
    end

    // Watchdog cuts a hang short well past the expected run of about 115 cycles.
    initial begin
        #(3000 * 100);
        failures++;
        give_verdict();
    end
endmodule : csr_sysctl_regs_bench
